//--- logic/cbs_bus_unit.sv
// Local bus strobe sequencer with interrupt, wait-test, reset and mode inputs.
// Assumes the ready and hold inputs are already synchronous to the clock.
// Notes on behaviour
// - Read strobe low in state two, state three and every wait state.
// - Strobe stays high in state two until the address/data bus floats.
// - During hold grant the strobe floats, reading as a logic one.
// - Memory/IO status line tells devices which space a strobe addresses.
// - Maskable request is a high level sampled in an instruction's last cycle.
// - Maskable request ignored while interrupts disabled; synchronised internally.
// - Accepted non-maskable interrupt yields a vector address into the memory table.
// - Wait instruction proceeds on test low, otherwise idles.
// - Test input resampled every rising clock edge.
// - Non-maskable input is edge triggered, type two, never masked.
// - Synchronised rising edge starts the interrupt after the current instruction.
// - Reset abandons any bus cycle at once.
// - Reset synchronised; a restart pulse marks its return low.
// - Mode select picks minimum or maximum pin functions.
// - Status line high for memory, low for IO, valid state four to state four.
// - Hold grant given mid state four or idle in minimum mode only, floating bus lines together.
`timescale 1ns/1ns
module cbs_bus_unit
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // System inputs
  input wire logic I_CPU_RESET,
  input wire logic I_OPERATING_MODE_SELECT,
  input wire logic I_READY,
  input wire logic I_HOLD,
  input wire logic I_MASKABLE_IRQ_REQUEST,
  input wire logic I_NMI,
  input wire logic I_TEST_N,
  // Core side
  input wire logic I_REQ_VALID,
  input wire cbs_pkg::cbs_req_t I_REQ,
  input wire logic I_IRQ_ENABLE,
  input wire logic I_INSTR_LAST,
  input wire logic I_WAIT_INSTR,
  output logic O_REQ_TAKEN,
  output logic O_REQ_DONE,
  output logic [15:0] O_RDATA,
  output logic [1:0] O_INT_KIND,
  output logic [19:0] O_VECTOR_ADDR,
  output logic O_WAIT_IDLE,
  output logic O_RESTART,
  output logic O_MODE_MIN,
  output cbs_pkg::cbs_state_t O_BUS_STATE,
  // Local bus pins
  input wire logic [15:0] I_AD_I,
  output logic [15:0] O_AD_O,
  output logic O_AD_OE,
  output logic O_ALE,
  output logic O_RD_N_O,
  output logic O_RD_N_OE,
  output logic O_WR_N_O,
  output logic O_WR_N_OE,
  output logic O_MIO_O,
  output logic O_MIO_OE,
  output logic O_HOLD_GRANT_OUTPUT
);
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [cbs_pkg::SYNC_BITS-1:0] sync;
  logic cpu_rst;
  logic cpu_rst_d;
  logic nmi_d;
  logic nmi_pending;
  logic phase;
  logic pend;
  logic write_cyc;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic in_gap;
  // Release the system reset through two flops
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];
  // Synchronise reset, test, maskable and non-maskable inputs
  cbs_sync u_sync
  (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_async({I_NMI, I_MASKABLE_IRQ_REQUEST, I_TEST_N, I_CPU_RESET}),
    .o_sync(sync)
  );
  assign cpu_rst = sync[cbs_pkg::SYNC_RESET];
  assign in_gap = (O_BUS_STATE == cbs_pkg::BUS_IDLE) || (O_BUS_STATE == cbs_pkg::BUS_STATE_FOUR);
  // Reset edge tracking and restart pulse on the falling edge
  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_rst_d <= 1'b0;
      O_RESTART <= 1'b0;
    end
    else
    begin
      cpu_rst_d <= cpu_rst;
      O_RESTART <= cpu_rst_d && !cpu_rst;
    end
  end
  // Mode strap is caught while reset is held, so it never shifts mid-run
  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
      O_MODE_MIN <= 1'b1;
    else if (cpu_rst)
      O_MODE_MIN <= I_OPERATING_MODE_SELECT;
  end
  // Wait instruction idles while the resampled test input is high
  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
      O_WAIT_IDLE <= 1'b0;
    else
      O_WAIT_IDLE <= I_WAIT_INSTR && sync[cbs_pkg::SYNC_TEST] && !cpu_rst;
  end
  // Interrupt decision at an instruction's end; NMI outranks maskable, new edge stays set
  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmi_d <= 1'b0;
      nmi_pending <= 1'b0;
      O_INT_KIND <= cbs_pkg::INT_NONE;
      O_VECTOR_ADDR <= 20'h00000;
    end
    else
    begin
      nmi_d <= sync[cbs_pkg::SYNC_NMI];
      O_INT_KIND <= cbs_pkg::INT_NONE;
      if (cpu_rst)
        nmi_pending <= 1'b0;
      else if (I_INSTR_LAST && (nmi_pending || (sync[cbs_pkg::SYNC_NMI] && !nmi_d)))
      begin
        nmi_pending <= nmi_pending && sync[cbs_pkg::SYNC_NMI] && !nmi_d;
        O_INT_KIND <= cbs_pkg::INT_NMI;
        O_VECTOR_ADDR <= {10'h000, cbs_pkg::NMI_TYPE, 2'h0};
      end
      else
      begin
        if (sync[cbs_pkg::SYNC_NMI] && !nmi_d)
          nmi_pending <= 1'b1;
        if (I_INSTR_LAST && I_IRQ_ENABLE && sync[cbs_pkg::SYNC_MASKABLE])
          O_INT_KIND <= cbs_pkg::INT_MASKABLE;
      end
    end
  end
  // Bus state sequencer; each bus state but hold lasts two clocks so strobes can move mid-state
  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= cbs_pkg::PHASE_FIRST;
      pend <= 1'b0;
      write_cyc <= 1'b0;
      addr <= 16'h0000;
      wdata <= 16'h0000;
      O_BUS_STATE <= cbs_pkg::BUS_IDLE;
      O_REQ_TAKEN <= 1'b0;
      O_REQ_DONE <= 1'b0;
      O_RDATA <= 16'h0000;
      O_AD_O <= cbs_pkg::AD_IDLE;
      O_AD_OE <= 1'b0;
      O_ALE <= 1'b0;
      O_RD_N_O <= cbs_pkg::STROBE_IDLE;
      O_RD_N_OE <= 1'b1;
      O_WR_N_O <= cbs_pkg::STROBE_IDLE;
      O_WR_N_OE <= 1'b1;
      O_MIO_O <= 1'b1;
      O_MIO_OE <= 1'b1;
      O_HOLD_GRANT_OUTPUT <= 1'b0;
    end
    else if (cpu_rst)
    begin
      phase <= cbs_pkg::PHASE_FIRST;
      pend <= 1'b0; // Abandoned at once, never completed
      O_BUS_STATE <= cbs_pkg::BUS_IDLE;
      O_REQ_TAKEN <= 1'b0;
      O_REQ_DONE <= 1'b0;
      O_AD_OE <= 1'b0;
      O_ALE <= 1'b0;
      O_RD_N_O <= cbs_pkg::STROBE_IDLE;
      O_RD_N_OE <= 1'b1;
      O_WR_N_O <= cbs_pkg::STROBE_IDLE;
      O_WR_N_OE <= 1'b1;
      O_MIO_OE <= 1'b1;
      O_HOLD_GRANT_OUTPUT <= 1'b0;
    end
    else
    begin
      phase <= ~phase;
      O_REQ_TAKEN <= 1'b0;
      O_REQ_DONE <= 1'b0;
      if (O_BUS_STATE == cbs_pkg::BUS_HOLD)
      begin
        // Leave hold as soon as the request drops; lines driven again high
        phase <= cbs_pkg::PHASE_FIRST;
        if (!I_HOLD)
        begin
          O_HOLD_GRANT_OUTPUT <= 1'b0;
          O_BUS_STATE <= cbs_pkg::BUS_IDLE;
          O_RD_N_OE <= 1'b1;
          O_WR_N_OE <= 1'b1;
          O_MIO_OE <= 1'b1;
        end
      end
      else if (phase == cbs_pkg::PHASE_FIRST) // Middle of a state
      begin
        if (in_gap && !pend && O_MODE_MIN && I_HOLD)
        begin
          O_HOLD_GRANT_OUTPUT <= 1'b1;
          O_BUS_STATE <= cbs_pkg::BUS_HOLD;
          O_AD_OE <= 1'b0;
          O_RD_N_O <= cbs_pkg::STROBE_IDLE;
          O_RD_N_OE <= 1'b0;
          O_WR_N_O <= cbs_pkg::STROBE_IDLE;
          O_WR_N_OE <= 1'b0;
          O_MIO_O <= 1'b1;
          O_MIO_OE <= 1'b0;
        end
        else if (in_gap && !pend && I_REQ_VALID)
        begin
          pend <= 1'b1;
          O_REQ_TAKEN <= 1'b1;
          write_cyc <= I_REQ.write;
          addr <= I_REQ.addr;
          wdata <= I_REQ.wdata;
          O_MIO_O <= !I_REQ.io;
        end
        else if (O_BUS_STATE == cbs_pkg::BUS_STATE_TWO && !write_cyc && !O_AD_OE)
          O_RD_N_O <= 1'b0;
      end
      else // End of a state
      begin
        case (O_BUS_STATE)
          cbs_pkg::BUS_IDLE, cbs_pkg::BUS_STATE_FOUR:
          begin
            if (pend)
            begin
              O_BUS_STATE <= cbs_pkg::BUS_STATE_ONE;
              O_AD_O <= addr;
              O_AD_OE <= 1'b1;
              O_ALE <= 1'b1;
            end
            else
              O_BUS_STATE <= cbs_pkg::BUS_IDLE;
          end
          cbs_pkg::BUS_STATE_ONE:
          begin
            O_BUS_STATE <= cbs_pkg::BUS_STATE_TWO;
            O_ALE <= 1'b0;
            pend <= 1'b0;
            if (write_cyc)
            begin
              O_AD_O <= wdata;
              O_WR_N_O <= 1'b0;
            end
            else
              O_AD_OE <= 1'b0;
          end
          cbs_pkg::BUS_STATE_TWO:
            O_BUS_STATE <= cbs_pkg::BUS_STATE_THREE;
          cbs_pkg::BUS_STATE_THREE, cbs_pkg::BUS_WAIT_STATE:
          begin
            // Ready is used raw; its setup is the clock source's duty
            if (I_READY)
            begin
              O_BUS_STATE <= cbs_pkg::BUS_STATE_FOUR;
              O_RD_N_O <= cbs_pkg::STROBE_IDLE;
              O_WR_N_O <= cbs_pkg::STROBE_IDLE;
              O_AD_OE <= 1'b0;
              O_REQ_DONE <= 1'b1;
              if (!write_cyc)
                O_RDATA <= I_AD_I;
            end
            else
              O_BUS_STATE <= cbs_pkg::BUS_WAIT_STATE;
          end
          default:
            O_BUS_STATE <= cbs_pkg::BUS_IDLE;
        endcase
      end
    end
  end
endmodule : cbs_bus_unit

//--- logic/cbs_pkg.sv
// Shared constants and types for the local bus strobe and system input block.
// Assumes a single 125 MHz clock; every bus state other than hold spans two clock cycles (two phases).
package cbs_pkg;

  // Clock figures
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MIN_CYCLES = 4;

  // Synchroniser depth for the system inputs
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_BITS = 4;
  localparam int SYNC_RESET = 0;
  localparam int SYNC_TEST = 1;
  localparam int SYNC_MASKABLE = 2;
  localparam int SYNC_NMI = 3;

  // Widths
  localparam int DATA_W = 16;
  localparam int TYPE_W = 8;
  localparam int VEC_W = 20;

  // Interrupt type raised by the non-maskable input
  localparam logic [7:0] NMI_TYPE = 8'h02;

  // Phase within a bus state: first half, second half
  localparam logic PHASE_FIRST = 1'b0;
  localparam logic PHASE_SECOND = 1'b1;

  // Idle (floated or driven-high) pin values
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [15:0] AD_IDLE = 16'h0000;

  // Interrupt kind reported to the core
  localparam logic [1:0] INT_NONE = 2'h0;
  localparam logic [1:0] INT_MASKABLE = 2'h1;
  localparam logic [1:0] INT_NMI = 2'h2;

  // Bus states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_STATE_ONE = 3'b001,
    BUS_STATE_TWO = 3'b010,
    BUS_STATE_THREE = 3'b011,
    BUS_WAIT_STATE = 3'b100,
    BUS_STATE_FOUR = 3'b101,
    BUS_HOLD = 3'b110
  } cbs_state_t;

  // Bus cycle request from the core
  typedef struct packed {
    logic write;
    logic io;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cbs_req_t;

endpackage : cbs_pkg

//--- logic/cbs_sync.sv
// Multi-bit two-flop synchroniser for independent level inputs.
// Assumes each bit is an unrelated level; no word coherence is offered.
`timescale 1ns/1ns
module cbs_sync
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [cbs_pkg::SYNC_BITS-1:0] i_async,
  output logic [cbs_pkg::SYNC_BITS-1:0] o_sync
);

  logic [cbs_pkg::SYNC_BITS-1:0] meta;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < cbs_pkg::SYNC_BITS; g = g + 1)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end
        else
        begin
          meta[g] <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule : cbs_sync

//--- verification/cbs_bus_properties.sv
// Checker for the local bus strobe block, watching top-level ports only.
// Assumes it is bound to cbs_bus_unit and shares its single clock.
`timescale 1ns/1ns
module cbs_bus_properties
(
  // Clock, reset and system inputs
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_READY,
  input wire logic I_CPU_RESET,
  input wire logic I_IRQ_ENABLE,
  input wire logic I_INSTR_LAST,
  // Outputs under watch
  input wire logic O_REQ_DONE,
  input wire logic [1:0] O_INT_KIND,
  input wire logic [19:0] O_VECTOR_ADDR,
  input wire cbs_pkg::cbs_state_t O_BUS_STATE,
  input wire logic O_AD_OE,
  input wire logic O_RD_N_O,
  input wire logic O_RD_N_OE,
  input wire logic O_WR_N_O,
  input wire logic O_MIO_O,
  input wire logic O_ALE,
  input wire logic O_MIO_OE,
  input wire logic O_HOLD_GRANT_OUTPUT
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);
  // Strobe and float relations
  a_rd_strobe_low: assert property ((O_BUS_STATE inside {cbs_pkg::BUS_STATE_THREE,
    cbs_pkg::BUS_WAIT_STATE}) && O_WR_N_O |-> !O_RD_N_O) else $error("read strobe high");
  a_rd_after_float: assert property (!O_RD_N_O |-> !O_AD_OE)
    else $error("strobe before float");
  a_hold_floats: assert property (O_HOLD_GRANT_OUTPUT |->
    !O_RD_N_OE && O_RD_N_O && !O_MIO_OE) else $error("pins driven in hold");
  a_hold_in_gap: assert property ($rose(O_HOLD_GRANT_OUTPUT) |->
    $past(O_BUS_STATE) inside {cbs_pkg::BUS_IDLE, cbs_pkg::BUS_STATE_FOUR})
    else $error("hold granted mid cycle");
  a_mio_stable: assert property (O_BUS_STATE inside {cbs_pkg::BUS_STATE_ONE,
    cbs_pkg::BUS_STATE_TWO, cbs_pkg::BUS_STATE_THREE, cbs_pkg::BUS_WAIT_STATE}
    |-> $stable(O_MIO_O)) else $error("status line moved in cycle");
  a_ale_state_one: assert property (O_ALE |-> O_BUS_STATE == cbs_pkg::BUS_STATE_ONE)
    else $error("address strobe outside state one");
  // Cycle end only on ready, always into state four
  a_done_on_ready: assert property (O_REQ_DONE |-> $past(I_READY))
    else $error("done early");
  a_done_state_four: assert property (O_REQ_DONE |-> O_BUS_STATE == cbs_pkg::BUS_STATE_FOUR)
    else $error("done outside four");
  // Interrupt entry
  a_int_at_last: assert property (O_INT_KIND != cbs_pkg::INT_NONE |->
    $past(I_INSTR_LAST)) else $error("interrupt mid instruction");
  a_mask_enable: assert property (O_INT_KIND == cbs_pkg::INT_MASKABLE |->
    $past(I_IRQ_ENABLE)) else $error("masked request taken");
  a_nmi_vector: assert property (O_INT_KIND == cbs_pkg::INT_NMI |->
    ##[0:1] O_VECTOR_ADDR == 20'h00008) else $error("wrong vector");
  // A held reset has abandoned the bus by its fourth sample
  a_reset_idle: assert property (I_CPU_RESET [*4] |-> O_BUS_STATE == cbs_pkg::BUS_IDLE)
    else $error("bus not abandoned");
  c_wait: cover property (O_BUS_STATE == cbs_pkg::BUS_WAIT_STATE);
  c_hold: cover property (O_HOLD_GRANT_OUTPUT);
  c_nmi: cover property (O_INT_KIND == cbs_pkg::INT_NMI);
endmodule : cbs_bus_properties

bind cbs_bus_unit cbs_bus_properties u_cbs_bus_properties (.I_MCLK, .I_RST_N, .I_READY,
  .I_CPU_RESET, .I_IRQ_ENABLE, .I_INSTR_LAST, .O_REQ_DONE, .O_INT_KIND, .O_VECTOR_ADDR,
  .O_BUS_STATE, .O_AD_OE, .O_RD_N_O, .O_RD_N_OE, .O_WR_N_O, .O_MIO_O, .O_ALE, .O_MIO_OE,
  .O_HOLD_GRANT_OUTPUT);

//--- verification/cbs_bus_partner.sv
// Memory and IO devices on the far side of the local bus.
// Assumes direct pin access; ready is registered here, as a clock source would.
`timescale 1ns/1ns
module cbs_bus_partner
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pins from the block
  input wire logic [15:0] i_ad,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_mio,
  input wire logic [3:0] i_wait,
  // Pins to the block, last write seen
  output logic [15:0] o_ad,
  output logic o_ready,
  output logic [15:0] o_waddr,
  output logic [15:0] o_wdata,
  output logic o_wmem
);
  logic [15:0] addr;
  logic [15:0] last;
  logic mem;
  logic [4:0] cnt;
  // Read data only under a low strobe; a released bus toggles so stale data never passes
  assign o_ad = !i_rd_n ? (mem ? addr ^ 16'h5A3C : ~addr) : ~last;
  // Address and space decoded from the status line at the address strobe
  always_ff @(posedge i_clk)
  begin
    last <= o_ad;
    if (i_ale)
    begin
      addr <= i_ad;
      mem <= i_mio;
    end
    if (!i_wr_n)
    begin
      o_waddr <= addr;
      o_wdata <= i_ad;
      o_wmem <= mem;
    end
  end
  // Ready only after the chosen number of strobe cycles, already synchronous
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= 5'h00;
      o_ready <= 1'h0;
    end
    else
    begin
      cnt <= (i_rd_n && i_wr_n) ? 5'h00 : cnt + 5'h01;
      o_ready <= !(i_rd_n && i_wr_n) && cnt >= {1'h0, i_wait};
    end
  end
endmodule : cbs_bus_partner

//--- verification/test_cbs_bus_unit.sv
// Self-checking bench for cbs_bus_unit against a memory and IO partner.
// Assumes one 125 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(c) begin for (k = 0; k < 200 && ((c) !== 1'h1); k++) tick(1); \
  if ((c) !== 1'h1) begin n_fail++; summarize(); end end
module test_cbs_bus_unit;
  logic I_MCLK = 1'h0, I_RST_N = 1'h0, I_CPU_RESET = 1'h1, I_OPERATING_MODE_SELECT = 1'h1;
  logic I_HOLD = 1'h0, I_MASKABLE_IRQ_REQUEST = 1'h0, I_NMI = 1'h0, I_TEST_N = 1'h1;
  logic I_REQ_VALID = 1'h0, I_IRQ_ENABLE = 1'h0, I_INSTR_LAST = 1'h0, I_WAIT_INSTR = 1'h0;
  logic I_READY, O_REQ_TAKEN, O_REQ_DONE, O_AD_OE, O_ALE, O_RD_N_O, O_RD_N_OE, O_WR_N_O;
  logic O_WR_N_OE, O_MIO_O, O_MIO_OE, O_HOLD_GRANT_OUTPUT, O_WAIT_IDLE, O_RESTART;
  logic O_MODE_MIN, wmem;
  logic [15:0] O_RDATA, O_AD_O, I_AD_I, waddr, wdata;
  logic [1:0] O_INT_KIND;
  logic [19:0] O_VECTOR_ADDR;
  logic [3:0] wait_n = 4'h0;
  cbs_pkg::cbs_req_t I_REQ = '0;
  cbs_pkg::cbs_state_t O_BUS_STATE;
  int n_fail = 0, tests_run = 0, k;
  logic [15:0] exp_q[$];
  // Only rising edges are used, so a symmetric clock stands in for the third-high source
  always #4 I_MCLK = ~I_MCLK;
  cbs_bus_unit u_cbs_bus_unit (.I_MCLK, .I_RST_N, .I_CPU_RESET, .I_OPERATING_MODE_SELECT,
    .I_READY, .I_HOLD, .I_MASKABLE_IRQ_REQUEST, .I_NMI, .I_TEST_N, .I_REQ_VALID, .I_REQ,
    .I_IRQ_ENABLE, .I_INSTR_LAST, .I_WAIT_INSTR, .O_REQ_TAKEN, .O_REQ_DONE, .O_RDATA,
    .O_INT_KIND, .O_VECTOR_ADDR, .O_WAIT_IDLE, .O_RESTART, .O_MODE_MIN, .O_BUS_STATE,
    .I_AD_I, .O_AD_O, .O_AD_OE, .O_ALE, .O_RD_N_O, .O_RD_N_OE, .O_WR_N_O, .O_WR_N_OE,
    .O_MIO_O, .O_MIO_OE, .O_HOLD_GRANT_OUTPUT);
  cbs_bus_partner u_cbs_bus_partner (.i_clk(I_MCLK), .i_rst_n(I_RST_N), .i_ad(O_AD_O),
    .i_ale(O_ALE), .i_rd_n(O_RD_N_O), .i_wr_n(O_WR_N_O), .i_mio(O_MIO_O), .i_wait(wait_n),
    .o_ad(I_AD_I), .o_ready(I_READY), .o_waddr(waddr), .o_wdata(wdata), .o_wmem(wmem));
  task automatic tick(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask : tick
  task automatic summarize();
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  // One whole transfer; reads are scored against the queued expectation
  task automatic bus_op(input logic wr, input logic io, input logic [15:0] a,
    input logic [15:0] d);
    logic [15:0] e;
    I_REQ = '{write: wr, io: io, addr: a, wdata: d};
    I_REQ_VALID = 1'h1;
    `WAITF(O_REQ_TAKEN)
    I_REQ_VALID = 1'h0;
    if (!wr)
      exp_q.push_back(io ? ~a : a ^ 16'h5A3C);
    `WAITF(O_REQ_DONE)
    if (wr)
      `CHK({waddr, wdata, wmem}, {a, d, !io})
    else
    begin
      e = exp_q.pop_front();
      `CHK(O_RDATA, e)
    end
  endtask : bus_op
  // No interrupt may be reported for six cycles
  task automatic quiet();
    repeat (6)
    begin
      tick(1);
      `CHK(O_INT_KIND, cbs_pkg::INT_NONE)
    end
  endtask : quiet
  initial
  begin
    void'($urandom(9869));
    tick(3);
    I_RST_N = 1'h1;
    tick(8);
    I_CPU_RESET = 1'h0;
    `WAITF(O_RESTART)
    `CHK(O_MODE_MIN, 1'h1)
    // Random reads and writes in both spaces, back to back, up to three waits
    repeat (16)
    begin
      wait_n = 4'($urandom_range(3));
      bus_op(1'($urandom), 1'($urandom), 16'($urandom), 16'($urandom));
    end
    // Hold grant floats the bus and strobes
    I_HOLD = 1'h1;
    `WAITF(O_HOLD_GRANT_OUTPUT)
    `CHK({O_RD_N_OE, O_RD_N_O, O_MIO_OE, O_AD_OE}, 4'h4)
    `CHK({O_WR_N_OE, O_WR_N_O, O_MIO_O}, 3'h3)
    I_HOLD = 1'h0;
    `WAITF(!O_HOLD_GRANT_OUTPUT)
    `CHK({O_RD_N_OE, O_WR_N_OE, O_MIO_OE}, 3'h7)
    // Masked level, enabled level, then a held edge waiting for the instruction end
    I_MASKABLE_IRQ_REQUEST = 1'h1;
    I_INSTR_LAST = 1'h1;
    quiet();
    I_IRQ_ENABLE = 1'h1;
    `WAITF(O_INT_KIND == cbs_pkg::INT_MASKABLE)
    I_IRQ_ENABLE = 1'h0;
    I_INSTR_LAST = 1'h0;
    I_NMI = 1'h1;
    quiet();
    I_INSTR_LAST = 1'h1;
    `WAITF(O_INT_KIND == cbs_pkg::INT_NMI)
    tick(1);
    `CHK(O_VECTOR_ADDR, 20'h00008)
    quiet();
    // Wait instruction idles on a high test input
    I_WAIT_INSTR = 1'h1;
    `WAITF(O_WAIT_IDLE)
    I_TEST_N = 1'h0;
    `WAITF(!O_WAIT_IDLE)
    // Reset in the middle of a long read, switching to maximum mode
    wait_n = 4'hF;
    I_REQ = '{write: 1'h0, io: 1'h0, addr: 16'h1234, wdata: 16'h0000};
    I_REQ_VALID = 1'h1;
    `WAITF(O_REQ_TAKEN)
    I_REQ_VALID = 1'h0;
    `WAITF(!O_RD_N_O)
    `CHK(O_AD_OE, 1'h0)
    I_CPU_RESET = 1'h1;
    I_OPERATING_MODE_SELECT = 1'h0;
    tick(4);
    `CHK({O_BUS_STATE, O_RD_N_O}, {cbs_pkg::BUS_IDLE, 1'h1})
    tick(1);
    I_CPU_RESET = 1'h0;
    `WAITF(O_RESTART)
    `CHK(O_MODE_MIN, 1'h0)
    I_HOLD = 1'h1;
    tick(6);
    `CHK(O_HOLD_GRANT_OUTPUT, 1'h0)
    summarize();
  end
endmodule : test_cbs_bus_unit
